// [rtl/ctg_clamp_gen.sv]
`timescale 1ns/1ps
module ctg_clamp_gen
    import ctg_pkg::*;
(
    input  wire logic  i_ref_clk,
    input  wire logic  i_nrst,
    ctg_clamp_if.gen   cif
);
    ctg_cg_st_t       st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic             idle_q, idle_d;
    logic             clamp_q, clamp_d;
    logic             ext_act;

    always_comb
    begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        idle_d = idle_q;
        if (cif.hs_trail)
        begin
            idle_d = cif.ext_pin;
            // every trailing edge restarts, so at most one interval per line
            if (cif.dur == '0)
                st_d = CG_IDLE;
            else if (cif.place == '0)
            begin
                st_d  = CG_ACTIVE;
                cnt_d = cif.dur;
            end
            else
            begin
                st_d  = CG_WAIT;
                cnt_d = cif.place;
            end
        end
        else
        begin
            case (st_q)
                CG_WAIT:
                begin
                    cnt_d = cnt_q - 8'h01;
                    if (cnt_q == 8'h01)
                    begin
                        st_d  = CG_ACTIVE;
                        cnt_d = cif.dur;
                    end
                end
                CG_ACTIVE:
                begin
                    cnt_d = cnt_q - 8'h01;
                    if (cnt_q == 8'h01)
                        st_d = CG_IDLE;
                end
                default: st_d = CG_IDLE;
            endcase
        end
        // manual sense when top bit set, else active is opposite of line idle
        if (cif.pol[1])
            ext_act = (cif.ext_pin == cif.pol[0]);
        else
            ext_act = (cif.ext_pin != idle_q);
        clamp_d = cif.ext_sel ? ext_act : (st_d == CG_ACTIVE);
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_nrst)
        begin
            st_q    <= CG_IDLE;
            cnt_q   <= '0;
            idle_q  <= 1'b0;
            clamp_q <= 1'b0;
        end
        else
        begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            idle_q  <= idle_d;
            clamp_q <= clamp_d;
        end
    end

    assign cif.clamp = clamp_q;
endmodule : ctg_clamp_gen

// [rtl/ctg_clamp_if.sv]
`timescale 1ns/1ps
interface ctg_clamp_if;
    import ctg_pkg::*;
    logic             ext_sel;
    logic [1:0]       pol;
    logic [CNT_W-1:0] place;
    logic [CNT_W-1:0] dur;
    logic             hs_trail;
    logic             ext_pin;
    logic             clamp;

    modport ctrl (output ext_sel, output pol, output place, output dur,
                  output hs_trail, output ext_pin, input clamp);
    modport gen  (input ext_sel, input pol, input place, input dur,
                  input hs_trail, input ext_pin, output clamp);
endinterface : ctg_clamp_if

// [rtl/ctg_pkg.sv]
package ctg_pkg;

    // ------------------------------------------------------------
    // channels and widths
    // ------------------------------------------------------------
    localparam int NCH    = 3;
    localparam int GAIN_W = 7;
    localparam int OFF_W  = 9;
    localparam int MAN_W  = 7;
    localparam int CNT_W  = 8;
    localparam int TGT_W  = 8;

    // ------------------------------------------------------------
    // register offsets (channel 0 red, 1 green, 2 blue)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_GAIN  [NCH] = '{8'h05, 8'h07, 8'h09};
    localparam logic [7:0] ADDR_OFF_HI[NCH] = '{8'h0b, 8'h0d, 8'h0f};
    localparam logic [7:0] ADDR_OFF_LO[NCH] = '{8'h0c, 8'h0e, 8'h10};
    localparam logic [7:0] ADDR_CLAMP_CTRL  = 8'h18;
    localparam logic [7:0] ADDR_CLAMP_PLACE = 8'h19;
    localparam logic [7:0] ADDR_CLAMP_DUR   = 8'h1a;
    localparam logic [7:0] ADDR_AUTO_OFF    = 8'h1b;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CC_SRC_BIT          = 4;
    localparam int CC_POL_HI           = 7;
    localparam int CC_POL_LO           = 6;
    localparam int CC_SEL_BIT [NCH]    = '{3, 2, 1};
    localparam int AO_EN_BIT           = 5;
    localparam int OFF_LO_BIT          = 7;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [GAIN_W-1:0] RST_GAIN   = 7'h40;
    localparam logic [7:0]        RST_OFF_HI = 8'h00;
    localparam logic [7:0]        RST_OFF_LO = 8'h00;
    localparam logic [7:0]        RST_CC     = 8'h00;
    localparam logic [7:0]        RST_PLACE  = 8'h04;
    localparam logic [7:0]        RST_DUR    = 8'h28;
    localparam logic [7:0]        RST_AO     = 8'h00;

    // ------------------------------------------------------------
    // codes
    // ------------------------------------------------------------
    localparam logic [TGT_W-1:0] TGT_GND   = 8'h00;
    localparam logic [TGT_W-1:0] TGT_MID   = 8'h80;
    localparam logic [MAN_W-1:0] MAN_NEG64 = 7'h40;
    localparam logic [OFF_W-1:0] MAN_MIN   = 9'h1c1;

    // ------------------------------------------------------------
    // synchroniser lanes
    // ------------------------------------------------------------
    localparam int SYNC_W  = 4;
    localparam int SY_SCL  = 0;
    localparam int SY_SDA  = 1;
    localparam int SY_HS   = 2;
    localparam int SY_CLMP = 3;

    // ------------------------------------------------------------
    // state machines
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        I2C_IDLE  = 3'h0,
        I2C_ADDR  = 3'h1,
        I2C_ACK_A = 3'h3,
        I2C_WDATA = 3'h2,
        I2C_ACK_W = 3'h6,
        I2C_RDATA = 3'h7,
        I2C_ACK_R = 3'h5
    } ctg_i2c_st_t;

    typedef enum logic [1:0] {
        CG_IDLE   = 2'h0,
        CG_WAIT   = 2'h1,
        CG_ACTIVE = 2'h3
    } ctg_cg_st_t;

endpackage : ctg_pkg

// [rtl/ctg_sync2.sv]
`timescale 1ns/1ps
module ctg_sync2
    import ctg_pkg::*;
(
    input  wire logic              i_ref_clk,
    input  wire logic              i_nrst,
    input  wire logic [SYNC_W-1:0] i_d,
    output logic      [SYNC_W-1:0] o_q
);
    logic [SYNC_W-1:0] meta_q;
    logic [SYNC_W-1:0] meta_d;
    logic [SYNC_W-1:0] sync_q;
    logic [SYNC_W-1:0] sync_d;

    always_comb
    begin
        meta_d = i_d;
        sync_d = meta_q;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_nrst)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign o_q = sync_q;
endmodule : ctg_sync2

// [rtl/ctg_top.sv]
`timescale 1ns/1ps
module ctg_top
    import ctg_pkg::*;
#(
    // serial device address, arbitrary value
    parameter logic [6:0] DEV_ADDR = 7'h4c
)
(
    input  wire logic                        i_ref_clk,
    input  wire logic                        i_nrst,
    input  wire logic                        i_scl,
    input  wire logic                        i_sda,
    output logic                             o_sda,
    output logic                             o_sda_oen,
    input  wire logic                        i_hsync,
    input  wire logic                        i_clamp_pin,
    output logic                             o_clamp,
    output logic [NCH-1:0]                   o_clamp_mid,
    output logic [NCH-1:0]                   o_clamp_gnd,
    output logic [NCH-1:0][TGT_W-1:0]        o_clamp_target,
    output logic [NCH-1:0][GAIN_W-1:0]       o_gain_code,
    output logic [NCH-1:0][GAIN_W-1:0]       o_gain_level,
    output logic [NCH-1:0][OFF_W-1:0]        o_offset_val,
    output logic                             o_offset_auto
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] pins_s;
    logic              scl_s;
    logic              sda_s;
    logic              hs_s;

    ctg_sync2 u_sync (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_d       ({i_clamp_pin, i_hsync, i_sda, i_scl}),
        .o_q       (pins_s)
    );

    assign scl_s = pins_s[SY_SCL];
    assign sda_s = pins_s[SY_SDA];
    assign hs_s  = pins_s[SY_HS];

    // ------------------------------------------------------------
    // edge history
    // ------------------------------------------------------------
    logic scl_p_q, scl_p_d;
    logic sda_p_q, sda_p_d;
    logic hs_p_q,  hs_p_d;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;

    always_comb
    begin
        scl_p_d = scl_s;
        sda_p_d = sda_s;
        hs_p_d  = hs_s;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_nrst)
        begin
            // match the cleared synchroniser so no false falling edge or start follows reset
            scl_p_q <= 1'b0;
            sda_p_q <= 1'b0;
            hs_p_q  <= 1'b0;
        end
        else
        begin
            scl_p_q <= scl_p_d;
            sda_p_q <= sda_p_d;
            hs_p_q  <= hs_p_d;
        end
    end

    assign scl_rise = scl_s & ~scl_p_q;
    assign scl_fall = ~scl_s & scl_p_q;
    assign start    = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop     = scl_s & scl_p_q & ~sda_p_q & sda_s;

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [NCH-1:0][GAIN_W-1:0] gain_q,   gain_d;
    logic [NCH-1:0][7:0]        off_hi_q, off_hi_d;
    logic [NCH-1:0][7:0]        off_lo_q, off_lo_d;
    logic [7:0]                 cc_q,     cc_d;
    logic [CNT_W-1:0]           place_q,  place_d;
    logic [CNT_W-1:0]           dur_q,    dur_d;
    logic [7:0]                 ao_q,     ao_d;
    logic                       wr_en;
    logic [7:0]                 wr_addr;
    logic [7:0]                 wr_data;
    logic [7:0]                 rd_data;

    // ------------------------------------------------------------
    // serial slave
    // ------------------------------------------------------------
    ctg_i2c_st_t st_q, st_d;
    logic [2:0]  cnt_q, cnt_d;
    logic [7:0]  sh_q, sh_d;
    logic        full_q, full_d;
    logic [7:0]  ptr_q, ptr_d;
    logic        first_q, first_d;
    logic        rw_q, rw_d;
    logic        drv_q, drv_d;
    logic        nack_q, nack_d;

    always_comb
    begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        sh_d    = sh_q;
        full_d  = full_q;
        ptr_d   = ptr_q;
        first_d = first_q;
        rw_d    = rw_q;
        drv_d   = drv_q;
        nack_d  = nack_q;
        wr_en   = 1'b0;
        wr_addr = ptr_q;
        wr_data = sh_q;
        if (start)
        begin
            st_d    = I2C_ADDR;
            cnt_d   = '0;
            full_d  = 1'b0;
            drv_d   = 1'b0;
            first_d = 1'b1;
        end
        else if (stop)
        begin
            st_d  = I2C_IDLE;
            drv_d = 1'b0;
        end
        else if (scl_rise)
        begin
            case (st_q)
                I2C_ADDR, I2C_WDATA:
                begin
                    sh_d   = {sh_q[6:0], sda_s};
                    cnt_d  = cnt_q + 3'h1;
                    full_d = (cnt_q == 3'h7);
                end
                I2C_RDATA:
                begin
                    cnt_d  = cnt_q + 3'h1;
                    full_d = (cnt_q == 3'h7);
                end
                I2C_ACK_R: nack_d = sda_s;
                default: ;
            endcase
        end
        else if (scl_fall)
        begin
            case (st_q)
                I2C_ADDR:
                begin
                    if (full_q)
                    begin
                        full_d = 1'b0;
                        if (sh_q[7:1] == DEV_ADDR)
                        begin
                            st_d  = I2C_ACK_A;
                            drv_d = 1'b1;
                            rw_d  = sh_q[0];
                        end
                        else
                            st_d = I2C_IDLE;
                    end
                end
                I2C_ACK_A:
                begin
                    if (rw_q)
                    begin
                        st_d  = I2C_RDATA;
                        sh_d  = rd_data;
                        drv_d = ~rd_data[7];
                    end
                    else
                    begin
                        st_d  = I2C_WDATA;
                        drv_d = 1'b0;
                    end
                end
                I2C_WDATA:
                begin
                    if (full_q)
                    begin
                        full_d  = 1'b0;
                        st_d    = I2C_ACK_W;
                        drv_d   = 1'b1;
                        first_d = 1'b0;
                        // first byte after address is the register pointer
                        wr_en   = ~first_q;
                        ptr_d   = first_q ? sh_q : ptr_q + 8'h01;
                    end
                end
                I2C_ACK_W:
                begin
                    st_d  = I2C_WDATA;
                    drv_d = 1'b0;
                end
                I2C_RDATA:
                begin
                    if (full_q)
                    begin
                        full_d = 1'b0;
                        st_d   = I2C_ACK_R;
                        drv_d  = 1'b0;
                        ptr_d  = ptr_q + 8'h01;
                    end
                    else
                    begin
                        sh_d  = {sh_q[6:0], 1'b0};
                        drv_d = ~sh_q[6];
                    end
                end
                I2C_ACK_R:
                begin
                    if (nack_q)
                    begin
                        st_d  = I2C_IDLE;
                        drv_d = 1'b0;
                    end
                    else
                    begin
                        st_d  = I2C_RDATA;
                        sh_d  = rd_data;
                        drv_d = ~rd_data[7];
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_nrst)
        begin
            st_q    <= I2C_IDLE;
            cnt_q   <= '0;
            sh_q    <= '0;
            full_q  <= 1'b0;
            ptr_q   <= '0;
            first_q <= 1'b1;
            rw_q    <= 1'b0;
            drv_q   <= 1'b0;
            nack_q  <= 1'b0;
        end
        else
        begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            sh_q    <= sh_d;
            full_q  <= full_d;
            ptr_q   <= ptr_d;
            first_q <= first_d;
            rw_q    <= rw_d;
            drv_q   <= drv_d;
            nack_q  <= nack_d;
        end
    end

    // open drain: pin only ever pulled low
    assign o_sda     = 1'b0;
    assign o_sda_oen = ~drv_q;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    always_comb
    begin
        gain_d   = gain_q;
        off_hi_d = off_hi_q;
        off_lo_d = off_lo_q;
        cc_d     = cc_q;
        place_d  = place_q;
        dur_d    = dur_q;
        ao_d     = ao_q;
        if (wr_en)
        begin
            if (wr_addr == ADDR_CLAMP_CTRL)
                cc_d = wr_data;
            else if (wr_addr == ADDR_CLAMP_PLACE)
                place_d = wr_data;
            else if (wr_addr == ADDR_CLAMP_DUR)
                dur_d = wr_data;
            else if (wr_addr == ADDR_AUTO_OFF)
                ao_d = wr_data;
            for (int i = 0; i < NCH; i++)
            begin
                if (wr_addr == ADDR_GAIN[i])
                    gain_d[i] = wr_data[GAIN_W-1:0];
                else if (wr_addr == ADDR_OFF_HI[i])
                    off_hi_d[i] = wr_data;
                else if (wr_addr == ADDR_OFF_LO[i])
                    off_lo_d[i] = wr_data;
            end
        end
    end

    always_comb
    begin
        rd_data = 8'h00;
        if (ptr_q == ADDR_CLAMP_CTRL)
            rd_data = cc_q;
        else if (ptr_q == ADDR_CLAMP_PLACE)
            rd_data = place_q;
        else if (ptr_q == ADDR_CLAMP_DUR)
            rd_data = dur_q;
        else if (ptr_q == ADDR_AUTO_OFF)
            rd_data = ao_q;
        for (int i = 0; i < NCH; i++)
        begin
            if (ptr_q == ADDR_GAIN[i])
                rd_data = {1'b0, gain_q[i]};
            else if (ptr_q == ADDR_OFF_HI[i])
                rd_data = off_hi_q[i];
            else if (ptr_q == ADDR_OFF_LO[i])
                rd_data = off_lo_q[i];
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_nrst)
        begin
            gain_q   <= {NCH{RST_GAIN}};
            off_hi_q <= {NCH{RST_OFF_HI}};
            off_lo_q <= {NCH{RST_OFF_LO}};
            cc_q     <= RST_CC;
            place_q  <= RST_PLACE;
            dur_q    <= RST_DUR;
            ao_q     <= RST_AO;
        end
        else
        begin
            gain_q   <= gain_d;
            off_hi_q <= off_hi_d;
            off_lo_q <= off_lo_d;
            cc_q     <= cc_d;
            place_q  <= place_d;
            dur_q    <= dur_d;
            ao_q     <= ao_d;
        end
    end

    // ------------------------------------------------------------
    // clamp timing
    // ------------------------------------------------------------
    ctg_clamp_if u_cif ();

    assign u_cif.ext_sel  = cc_q[CC_SRC_BIT];
    assign u_cif.pol      = cc_q[CC_POL_HI:CC_POL_LO];
    assign u_cif.place    = place_q;
    assign u_cif.dur      = dur_q;
    assign u_cif.hs_trail = hs_p_q & ~hs_s;
    assign u_cif.ext_pin  = pins_s[SY_CLMP];

    ctg_clamp_gen u_clamp (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .cif       (u_cif)
    );

    assign o_clamp       = u_cif.clamp;
    assign o_offset_auto = ao_q[AO_EN_BIT];

    // ------------------------------------------------------------
    // per-channel settings
    // ------------------------------------------------------------
    for (genvar c = 0; c < NCH; c++)
    begin : g_ch
        logic [MAN_W-1:0] man;
        logic             mid;

        assign mid = cc_q[CC_SEL_BIT[c]];
        assign man = off_hi_q[c][MAN_W-1:0];

        always_comb
        begin
            // ground clamp pulls the black level to code zero
            o_clamp_target[c] = mid ? TGT_MID : TGT_GND;
            o_clamp_mid[c]    = u_cif.clamp & mid;
            o_clamp_gnd[c]    = u_cif.clamp & ~mid;
            o_gain_code[c]    = gain_q[c];
            // inverted code falls as the gain code rises, easing the analog ladder
            o_gain_level[c]   = ~gain_q[c];
            if (ao_q[AO_EN_BIT])
                o_offset_val[c] = {off_hi_q[c], off_lo_q[c][OFF_LO_BIT]};
            else if (man == MAN_NEG64)
                o_offset_val[c] = MAN_MIN;
            else
                o_offset_val[c] = {{(OFF_W-MAN_W){man[MAN_W-1]}}, man};
        end
    end

endmodule : ctg_top

// [test/ctg_monitor.sv]
`timescale 1ns/1ps
module ctg_monitor
    import ctg_pkg::*;
(
    input wire logic                        i_ref_clk,
    input wire logic                        i_nrst,
    input wire logic                        i_scl,
    input wire logic                        o_sda_oen,
    input wire logic                        o_clamp,
    input wire logic [NCH-1:0]              o_clamp_mid,
    input wire logic [NCH-1:0]              o_clamp_gnd,
    input wire logic [NCH-1:0][TGT_W-1:0]   o_clamp_target,
    input wire logic [NCH-1:0][GAIN_W-1:0]  o_gain_code,
    input wire logic [NCH-1:0][GAIN_W-1:0]  o_gain_level,
    input wire logic [NCH-1:0][OFF_W-1:0]   o_offset_val,
    input wire logic                        o_offset_auto
);
    logic tgt_ok;
    logic man_ok;
    always_comb
    begin
        tgt_ok = 1'b1;
        man_ok = 1'b1;
        for (int c = 0; c < NCH; c++)
        begin
            if (o_clamp_gnd[c] && o_clamp_target[c] != TGT_GND) tgt_ok = 1'b0;
            if (o_clamp_mid[c] && o_clamp_target[c] != TGT_MID) tgt_ok = 1'b0;
            if ($signed(o_offset_val[c]) > 63 || $signed(o_offset_val[c]) < -63) man_ok = 1'b0;
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    a_gain_inverse: assert property (o_gain_level == ~o_gain_code)
        else $error("gain level not inverse of code");
    a_clamp_exclusive: assert property ((o_clamp_mid & o_clamp_gnd) == '0)
        else $error("channel clamped to both targets");
    a_clamp_covers: assert property ((o_clamp_mid | o_clamp_gnd) == {NCH{o_clamp}})
        else $error("channel clamp differs from clamp");
    a_clamp_target: assert property (tgt_ok)
        else $error("clamp target code wrong");
    a_manual_range: assert property (!o_offset_auto |-> man_ok)
        else $error("manual offset out of range");
    a_gain_scl_low: assert property ($changed(o_gain_code) |-> !i_scl)
        else $error("gain changed outside a bus write");
    a_auto_scl_low: assert property ($changed(o_offset_auto) |-> !i_scl)
        else $error("offset mode changed outside a bus write");
    a_ack_hold: assert property ($fell(o_sda_oen) |-> !o_sda_oen[*8])
        else $error("data line released too early");
    c_clamp: cover property ($rose(o_clamp));
    c_ack: cover property ($fell(o_sda_oen));
    c_auto: cover property ($rose(o_offset_auto));
endmodule : ctg_monitor

bind ctg_top ctg_monitor ctg_monitor_i (.*);

// [test/ctg_src_model.sv]
`timescale 1ns/1ps
module ctg_src_model #(
    parameter int LINE = 400
)
(
    input  wire logic i_ref_clk,
    input  wire logic i_run,
    output logic      o_hsync
);
    int cnt = 0;
    initial o_hsync = 1'b0;
    // sync stays low while stopped, like an idle source
    always @(posedge i_ref_clk)
    begin
        #1;
        cnt = (cnt == LINE - 1) ? 0 : cnt + 1;
        o_hsync = i_run && cnt < 8;
    end
endmodule : ctg_src_model

// [test/ctg_top_tb_top.sv]
`timescale 1ns/1ps
module ctg_top_tb_top;
    import ctg_pkg::*;
    localparam logic [6:0] DEV = 7'h4c;
    localparam logic [7:0] GV [3] = '{8'h00, 8'h7f, 8'h15};
    localparam logic [7:0] OH [3] = '{8'h3f, 8'h41, 8'h40};
    localparam logic [7:0] OL [3] = '{8'h80, 8'h00, 8'h00};
    localparam logic [8:0] EM [3] = '{9'h03f, 9'h1c1, 9'h1c1};
    localparam logic [8:0] EA [3] = '{9'h07f, 9'h082, 9'h080};
    logic clk = 1'b0, nrst = 1'b0, scl = 1'b1, sda_m = 1'b1, pin = 1'b0, run = 1'b0;
    logic hs, hs_q = 1'b0, o_sda, o_sda_oen, o_clamp, o_auto;
    int   hs_age = 0, err_count = 0, n_checks = 0;
    logic [NCH-1:0] mid, gnd;
    logic [NCH-1:0][TGT_W-1:0] tgt;
    logic [NCH-1:0][GAIN_W-1:0] gcode, glvl;
    logic [NCH-1:0][OFF_W-1:0] offv;
    // open drain: low enable pulls the shared line down
    wire  sda_w = sda_m & (o_sda_oen | o_sda);

    always #2.5 clk = ~clk;
    always @(posedge clk)
    begin
        hs_q   <= hs;
        hs_age <= (hs_q && !hs) ? 0 : hs_age + 1;
    end

    ctg_src_model ctg_src_model_i (.i_ref_clk(clk), .i_run(run), .o_hsync(hs));
    ctg_top ctg_top_i (.i_ref_clk(clk), .i_nrst(nrst), .i_scl(scl), .i_sda(sda_w),
        .o_sda(o_sda), .o_sda_oen(o_sda_oen), .i_hsync(hs), .i_clamp_pin(pin),
        .o_clamp(o_clamp), .o_clamp_mid(mid), .o_clamp_gnd(gnd), .o_clamp_target(tgt),
        .o_gain_code(gcode), .o_gain_level(glvl), .o_offset_val(offv), .o_offset_auto(o_auto));

    // ------
    // tasks
    // ------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
        n_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // slow bus phases leave room for the input synchronisers
    task automatic xbit(input logic b, output logic r);
        sda_m = b;
        tick(8);
        scl = 1'b1;
        tick(8);
        r = sda_w;
        scl = 1'b0;
        tick(2);
    endtask : xbit
    task automatic xbyte(input logic [7:0] d, input logic ma, output logic [7:0] r,
                         output logic sa);
        for (int i = 7; i >= 0; i--) xbit(d[i], r[i]);
        xbit(ma, sa);
    endtask : xbyte
    task automatic wb(input logic [7:0] d);
        logic [7:0] r;
        logic a;
        xbyte(d, 1'b1, r, a);
        chk("ack", 9'h0, {8'h0, a});
    endtask : wb
    task automatic bstart();
        sda_m = 1'b1;
        tick(8);
        scl = 1'b1;
        tick(8);
        sda_m = 1'b0;
        tick(8);
        scl = 1'b0;
        tick(2);
    endtask : bstart
    task automatic bstop();
        sda_m = 1'b0;
        tick(8);
        scl = 1'b1;
        tick(8);
        sda_m = 1'b1;
        tick(8);
    endtask : bstop
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        bstart();
        wb({DEV, 1'b0});
        wb(a);
        wb(d);
        bstop();
    endtask : reg_wr
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        logic k;
        bstart();
        wb({DEV, 1'b0});
        wb(a);
        bstart();
        wb({DEV, 1'b1});
        xbyte(8'hff, 1'b1, v, k);
        bstop();
        chk($sformatf("reg %h", a), {1'b0, e}, {1'b0, v});
    endtask : rchk
    task automatic wcl(input logic v);
        int n;
        n = 0;
        while (o_clamp !== v)
        begin
            tick(1);
            n++;
            if (n > 2000)
            begin
                err_count++;
                final_report();
            end
        end
    endtask : wcl
    // second interval only: the first may straddle a register write
    task automatic meas(input logic [2:0] em, output int dly, output int len);
        wcl(1'b0);
        wcl(1'b1);
        wcl(1'b0);
        wcl(1'b1);
        dly = hs_age;
        chk("mid", {6'h0, em}, {6'h0, mid});
        for (len = 0; o_clamp === 1'b1 && len < 300; len++) tick(1);
    endtask : meas
    task automatic pls(input logic v);
        tick(30);
        pin = v;
        tick(20);
        pin = ~v;
    endtask : pls

    // ------
    // sequence
    // ------
    initial
    begin
        logic [7:0] v;
        logic a;
        int d0, d1, l;
        tick(10);
        nrst = 1'b1;
        tick(4);
        for (int c = 0; c < NCH; c++) rchk(ADDR_GAIN[c], {1'b0, RST_GAIN});
        rchk(ADDR_CLAMP_PLACE, 8'h04);
        rchk(ADDR_CLAMP_DUR, 8'h28);
        rchk(8'h30, 8'h00);
        bstart();
        xbyte({7'h11, 1'b0}, 1'b1, v, a);
        bstop();
        chk("foreign address ack", 9'h1, {8'h0, a});
        for (int c = 0; c < NCH; c++) reg_wr(ADDR_GAIN[c], GV[c]);
        for (int c = 0; c < NCH; c++)
        begin
            chk("gain code", {2'h0, GV[c][6:0]}, {2'h0, gcode[c]});
            chk("gain level", {2'h0, 7'h7f - GV[c][6:0]}, {2'h0, glvl[c]});
            rchk(ADDR_GAIN[c], GV[c]);
            reg_wr(ADDR_OFF_HI[c], OH[c]);
            reg_wr(ADDR_OFF_LO[c], OL[c]);
        end
        for (int c = 0; c < NCH; c++) chk("manual offset", EM[c], offv[c]);
        reg_wr(ADDR_AUTO_OFF, 8'h20);
        chk("auto", 9'h1, {8'h0, o_auto});
        for (int c = 0; c < NCH; c++) chk("auto offset", EA[c], offv[c]);
        reg_wr(ADDR_AUTO_OFF, 8'h00);
        run = 1'b1;
        pin = 1'b1;
        reg_wr(ADDR_CLAMP_CTRL, 8'h0a);
        meas(3'b101, d0, l);
        chk("clamp len", 9'd40, l[8:0]);
        reg_wr(ADDR_CLAMP_PLACE, 8'h0a);
        meas(3'b101, d1, l);
        chk("placement shift", 9'd6, 9'(d1 - d0));
        reg_wr(ADDR_CLAMP_DUR, 8'hff);
        meas(3'b101, d1, l);
        chk("clamp max len", 9'd255, l[8:0]);
        pin = 1'b0;
        reg_wr(ADDR_CLAMP_CTRL, 8'hd0);
        fork
            meas(3'b000, d0, l);
            repeat (2) pls(1'b1);
        join
        chk("ext high len", 9'd20, l[8:0]);
        pin = 1'b1;
        reg_wr(ADDR_CLAMP_CTRL, 8'h90);
        fork
            meas(3'b000, d0, l);
            repeat (2) pls(1'b0);
        join
        chk("ext low len", 9'd20, l[8:0]);
        tick(10);
        final_report();
    end
endmodule : ctg_top_tb_top
